// ---- logic/fkm_top.sv ----
/*
 * Flash command sequencer for the backdoor key check and the user and
 * field read margin commands, with an Avalon-MM register slave.
 * Assumes one 50 MHz clock, stored keys readable with one clock latency,
 * and a special-mode strap coming from a pin.
 */
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
`include "fkm_defines.svh"

module fkm_top #(
	parameter int NUM_BLOCKS = 2
) (
	input wire logic clk, // 50 MHz module clock
	input wire logic resetn, // async reset, active low
	input wire logic [4:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic special_mode_pin, // special operating mode strap
	output logic [22:0] key_rd_addr, // stored key read address
	input wire logic [15:0] key_rd_data, // stored key word
	input wire logic [6:0] read_block, // block the array is reading
	output logic [2:0] read_margin, // margin level for that read
	output logic secured // device is secured
);

	// ======================================================================
	// declarations
	fkm_pkg::fkm_seq_t seq_reg;
	logic cmd_complete_reg;
	logic access_error_reg;
	logic key_fail_reg;
	logic [2:0] index_reg;
	logic [15:0] cob_reg [6];
	logic [7:0] security_reg;
	logic [6:0] margin_sel_reg;
	logic [1:0] mode_sync_reg;
	logic ack_reg;
	logic bus_req;
	logic bus_wr;
	logic launch;
	logic err_set;
	logic margin_wr;
	logic key_start;
	logic key_done;
	logic key_match;
	logic [1:0] key_sel;
	logic [2:0] sw_level;
	logic [7:0] cmd_code;
	logic [6:0] cmd_block;
	logic [15:0] cmd_setting;
	logic special_mode;
	logic [31:0] rd_mux;

	// field pick-outs of command word 0 and 1
	// block and setting fields
	assign cmd_code = cob_reg[0][15:8];
	assign cmd_block = cob_reg[0][6:0];
	assign cmd_setting = cob_reg[1];
	assign special_mode = mode_sync_reg[1];
	assign secured = security_reg[`FKM_SEC_SEC_HI:`FKM_SEC_SEC_LO] != `FKM_SEC_UNSECURED;

	// checks whether a margin command may run
	function automatic logic margin_ok(input logic [7:0] code, input logic [2:0] idx,
		input logic [6:0] blk, input logic [15:0] setting, input logic special);
		logic [15:0] limit;
		limit = `FKM_MARGIN_USER_MAX;
		if (code == `FKM_CMD_FIELD_MARGIN) begin
			limit = `FKM_MARGIN_FIELD_MAX;
		end
		margin_ok = (idx == `FKM_IDX_MARGIN) && (int'(blk) < NUM_BLOCKS) &&
			(setting <= limit) && (code != `FKM_CMD_FIELD_MARGIN || special);
	endfunction

	// ======================================================================
	// avalon slave: one wait cycle, answer on the second edge
	assign bus_req = (avs_read || avs_write) && !ack_reg;
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign bus_wr = avs_write && ack_reg && avs_byteenable[0]; // acts at the completing edge

	// acknowledge flop, drops after each answer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= bus_req;
		end
	end

	// read data mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			`FKM_OFS_STATUS: begin
				rd_mux[`FKM_ST_CMD_COMPLETE] = cmd_complete_reg;
				rd_mux[`FKM_ST_ACCESS_ERROR] = access_error_reg;
			end
			`FKM_OFS_INDEX: rd_mux[2:0] = index_reg;
			`FKM_OFS_CMDWORD: begin
				if (index_reg < 3'h6) begin
					rd_mux[15:0] = cob_reg[index_reg];
				end
			end
			`FKM_OFS_SECURITY: rd_mux[7:0] = security_reg;
			`FKM_OFS_MARGIN: begin
				rd_mux[6:0] = margin_sel_reg;
				rd_mux[18:16] = sw_level;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data captured at the first edge, ending the wait cycle, ahead of the answer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && bus_req) begin
			avs_readdata <= rd_mux;
		end
	end

	// ======================================================================
	// mode strap synchroniser
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_sync_reg <= 2'b00;
		end else begin
			mode_sync_reg <= {mode_sync_reg[0], special_mode_pin};
		end
	end

	// ======================================================================
	// software-writable registers, frozen while a command runs except the margin readback select
	// busy write guard
	assign launch = bus_wr && cmd_complete_reg && avs_address == `FKM_OFS_STATUS &&
		avs_writedata[`FKM_ST_CMD_COMPLETE];

	// index and command object words
	// indexed word load
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			index_reg <= 3'h0;
			for (int i = 0; i < 6; i++) begin
				cob_reg[i] <= 16'h0000;
			end
		end else if (bus_wr && cmd_complete_reg) begin
			if (avs_address == `FKM_OFS_INDEX) begin
				index_reg <= avs_writedata[2:0];
			end
			if (avs_address == `FKM_OFS_CMDWORD && index_reg < 3'h6 && avs_byteenable[1]) begin
				cob_reg[index_reg] <= avs_writedata[15:0];
			end
		end
	end

	// margin readback select
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			margin_sel_reg <= 7'h00;
		end else if (bus_wr && avs_address == `FKM_OFS_MARGIN) begin
			margin_sel_reg <= avs_writedata[6:0];
		end
	end

	// security register; key match releases security
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			security_reg <= `FKM_SECURITY_RESET;
		end else if (key_done && key_match) begin
			security_reg[`FKM_SEC_SEC_HI:`FKM_SEC_SEC_LO] <= `FKM_SEC_UNSECURED;
		end else if (bus_wr && cmd_complete_reg && avs_address == `FKM_OFS_SECURITY) begin
			security_reg <= avs_writedata[7:0];
		end
	end

	// ======================================================================
	// command sequencer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seq_reg <= fkm_pkg::FKM_ST_IDLE;
		end else begin
			case (seq_reg)
				fkm_pkg::FKM_ST_IDLE: begin
					if (launch) begin
						seq_reg <= fkm_pkg::FKM_ST_DECODE;
					end
				end
				fkm_pkg::FKM_ST_DECODE: begin
					if (err_set) begin
						seq_reg <= fkm_pkg::FKM_ST_DONE;
					end else if (cmd_code == `FKM_CMD_KEY) begin
						seq_reg <= fkm_pkg::FKM_ST_KEY;
					end else begin
						seq_reg <= fkm_pkg::FKM_ST_MARGIN;
					end
				end
				fkm_pkg::FKM_ST_KEY: begin
					if (key_done) begin
						seq_reg <= fkm_pkg::FKM_ST_DONE;
					end
				end
				fkm_pkg::FKM_ST_MARGIN: seq_reg <= fkm_pkg::FKM_ST_DONE;
				fkm_pkg::FKM_ST_DONE: seq_reg <= fkm_pkg::FKM_ST_IDLE;
				default: seq_reg <= fkm_pkg::FKM_ST_IDLE;
			endcase
		end
	end

	// launch checks in the decode cycle
	always_comb begin
		err_set = 1'b0;
		if (seq_reg == fkm_pkg::FKM_ST_DECODE) begin
			case (cmd_code)
				`FKM_CMD_KEY: begin
					err_set = index_reg != `FKM_IDX_KEY || key_fail_reg ||
						security_reg[`FKM_KEN_HI:`FKM_KEN_LO] != `FKM_KEN_ON;
				end
				`FKM_CMD_USER_MARGIN, `FKM_CMD_FIELD_MARGIN: begin
					err_set = !margin_ok(cmd_code, index_reg, cmd_block, cmd_setting,
						special_mode);
				end
				default: err_set = 1'b1;
			endcase
		end else if (seq_reg == fkm_pkg::FKM_ST_KEY && key_done) begin
			err_set = !key_match;
		end
	end

	assign key_start = seq_reg == fkm_pkg::FKM_ST_DECODE && !err_set &&
		cmd_code == `FKM_CMD_KEY;
	assign margin_wr = seq_reg == fkm_pkg::FKM_ST_MARGIN;

	// ======================================================================
	// status flags; hardware set wins over software clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_complete_reg <= 1'b1;
			access_error_reg <= 1'b0;
		end else begin
			if (seq_reg == fkm_pkg::FKM_ST_DONE) begin
				cmd_complete_reg <= 1'b1;
			end else if (launch) begin
				cmd_complete_reg <= 1'b0;
			end
			if (err_set) begin
				access_error_reg <= 1'b1;
			end else if (bus_wr && avs_address == `FKM_OFS_STATUS &&
				avs_writedata[`FKM_ST_ACCESS_ERROR]) begin
				access_error_reg <= 1'b0;
			end
		end
	end

	// mismatch lockout, cleared only by reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			key_fail_reg <= 1'b0;
		end else if (seq_reg == fkm_pkg::FKM_ST_KEY && key_done && !key_match) begin
			key_fail_reg <= 1'b1;
		end
	end

	// ======================================================================
	// submodules
	// key word n at index n+1
	fkm_key_check u_key (
		.clk(clk),
		.resetn(resetn),
		.start(key_start),
		.user_key(cob_reg[3'(key_sel) + `FKM_IDX_KEY0]),
		.key_sel(key_sel),
		.key_rd_addr(key_rd_addr),
		.key_rd_data(key_rd_data),
		.done(key_done),
		.match(key_match)
	);

	fkm_margin_table #(
		.NUM_BLOCKS(NUM_BLOCKS)
	) u_margin (
		.clk(clk),
		.resetn(resetn),
		.wr_en(margin_wr),
		.wr_block(cmd_block),
		.wr_level(cmd_setting[2:0]),
		.sw_block(margin_sel_reg),
		.sw_level(sw_level),
		.rd_block(read_block),
		.rd_level(read_margin)
	);

endmodule // fkm_top

// ---- logic/fkm_defines.svh ----
/*
 * Offsets, field positions, reset values, command codes and index values
 * for the flash key and margin command sequencer.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, word aligned.
 */
`ifndef FKM_DEFINES_SVH
`define FKM_DEFINES_SVH

// ==========================================================================
// register byte offsets
`define FKM_OFS_STATUS 5'h00
`define FKM_OFS_INDEX 5'h04
`define FKM_OFS_CMDWORD 5'h08
`define FKM_OFS_SECURITY 5'h0C
`define FKM_OFS_MARGIN 5'h10

// ==========================================================================
// status register fields
`define FKM_ST_CMD_COMPLETE 7
`define FKM_ST_ACCESS_ERROR 5
`define FKM_ST_PROT_VIOL 4
`define FKM_ST_MGERR 1
`define FKM_ST_MGUNC 0

// security register fields and reset values
`define FKM_KEN_HI 7
`define FKM_KEN_LO 6
`define FKM_SEC_SEC_HI 1
`define FKM_SEC_SEC_LO 0
`define FKM_KEN_ON 2'b10
`define FKM_SEC_UNSECURED 2'b10
`define FKM_SECURITY_RESET 8'hFF

// ==========================================================================
// command codes and launch index values
`define FKM_CMD_KEY 8'h0C
`define FKM_CMD_USER_MARGIN 8'h0D
`define FKM_CMD_FIELD_MARGIN 8'h0E
`define FKM_IDX_KEY 3'b100
`define FKM_IDX_MARGIN 3'b001
`define FKM_IDX_KEY0 3'b001

// margin settings
`define FKM_MARGIN_NORMAL 16'h0000
`define FKM_MARGIN_USER_MAX 16'h0002
`define FKM_MARGIN_FIELD_MAX 16'h0004

// comparison key location in the configuration field
`define FKM_KEY_BASE_ADDR 23'h7F_FF00

`endif

// ---- logic/fkm_pkg.sv ----
/*
 * Types shared by the flash key and margin command sequencer.
 * Assumes nothing of its surroundings.
 */
package fkm_pkg;

	// ======================================================================
	// command sequencer states
	typedef enum logic [2:0] {
		FKM_ST_IDLE = 3'b000,
		FKM_ST_DECODE = 3'b001,
		FKM_ST_KEY = 3'b010,
		FKM_ST_MARGIN = 3'b011,
		FKM_ST_DONE = 3'b100
	} fkm_seq_t;

	// key comparison states
	typedef enum logic [1:0] {
		FKM_KC_IDLE = 2'b00,
		FKM_KC_FETCH = 2'b01,
		FKM_KC_CMP = 2'b10
	} fkm_kc_t;

endpackage

// ---- logic/fkm_key_check.sv ----
/*
 * Backdoor key comparison engine: fetches the four stored comparison words
 * from the configuration field and compares them with the supplied keys.
 * Assumes flash read data returns one clock after the address is issued.
 */
`timescale 1ns/100ps
`include "fkm_defines.svh"

module fkm_key_check (
	input wire logic clk, // module clock
	input wire logic resetn, // async reset, active low
	input wire logic start, // one-cycle start pulse
	input wire logic [15:0] user_key, // supplied key for key_sel
	output logic [1:0] key_sel, // key word being handled
	output logic [22:0] key_rd_addr, // stored key read address
	input wire logic [15:0] key_rd_data, // stored key word
	output logic done, // one-cycle finish pulse
	output logic match // all keys matched, valid with done
);

	fkm_pkg::fkm_kc_t state_reg;
	logic [1:0] sel_reg;
	logic miss_reg;
	logic miss_now;

	// key n sits one word above key n-1
	assign key_sel = sel_reg;
	assign key_rd_addr = `FKM_KEY_BASE_ADDR + {20'h0_0000, sel_reg, 1'b0};
	assign miss_now = miss_reg | (key_rd_data != user_key);

	// ======================================================================
	// fetch / compare walk over the four words
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= fkm_pkg::FKM_KC_IDLE;
			sel_reg <= 2'b00;
			miss_reg <= 1'b0;
			done <= 1'b0;
			match <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_reg)
				fkm_pkg::FKM_KC_IDLE: begin
					if (start) begin
						sel_reg <= 2'b00;
						miss_reg <= 1'b0;
						state_reg <= fkm_pkg::FKM_KC_FETCH;
					end
				end
				fkm_pkg::FKM_KC_FETCH: begin
					state_reg <= fkm_pkg::FKM_KC_CMP;
				end
				fkm_pkg::FKM_KC_CMP: begin
					miss_reg <= miss_now;
					if (sel_reg == 2'b11) begin
						done <= 1'b1;
						match <= !miss_now;
						state_reg <= fkm_pkg::FKM_KC_IDLE;
					end else begin
						sel_reg <= sel_reg + 2'b01;
						state_reg <= fkm_pkg::FKM_KC_FETCH;
					end
				end
				default: begin
					state_reg <= fkm_pkg::FKM_KC_IDLE;
				end
			endcase
		end
	end

endmodule // fkm_key_check

// ---- logic/fkm_margin_table.sv ----
/*
 * Per-block read margin level store with one write port, a software
 * readback port and a flash read-path port.
 * Assumes nothing of block numbers; it checks each one against NUM_BLOCKS.
 */
`timescale 1ns/100ps
`include "fkm_defines.svh"

module fkm_margin_table #(
	parameter int NUM_BLOCKS = 2
) (
	input wire logic clk, // module clock
	input wire logic resetn, // async reset, active low
	input wire logic wr_en, // write strobe
	input wire logic [6:0] wr_block, // block written
	input wire logic [2:0] wr_level, // level written
	input wire logic [6:0] sw_block, // block for readback
	output logic [2:0] sw_level, // readback level
	input wire logic [6:0] rd_block, // block being read by the array
	output logic [2:0] rd_level // level governing that read
);

	logic [2:0] level_mem [NUM_BLOCKS];

	// out-of-range selects read as normal
	function automatic logic [2:0] lookup(input logic [6:0] blk);
		lookup = 3'h0;
		if (int'(blk) < NUM_BLOCKS) begin
			lookup = level_mem[int'(blk)];
		end
	endfunction

	// ======================================================================
	// level storage, normal after reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				level_mem[i] <= 3'h0;
			end
		end else if (wr_en && int'(wr_block) < NUM_BLOCKS) begin
			level_mem[int'(wr_block)] <= wr_level;
		end
	end

	// both read ports
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sw_level <= 3'h0;
			rd_level <= 3'h0;
		end else begin
			sw_level <= lookup(sw_block);
			rd_level <= lookup(rd_block);
		end
	end

endmodule // fkm_margin_table

// ---- test/fkm_top_sva.sv ----
/*
 * Checker for fkm_top: bus stall, stored key fetch, security and margin outputs.
 * Assumes it sees only the top ports and is attached by the bind below.
 */
`timescale 1ns/100ps

module fkm_top_sva #(
	parameter int NUM_BLOCKS = 2
) (
	input wire logic clk, // module clock
	input wire logic resetn, // async reset, active low
	input wire logic [4:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	input wire logic [31:0] avs_readdata, // read data
	input wire logic avs_waitrequest, // stall
	input wire logic special_mode_pin, // special mode strap
	input wire logic [22:0] key_rd_addr, // stored key address
	input wire logic [15:0] key_rd_data, // stored key word
	input wire logic [6:0] read_block, // block read
	input wire logic [2:0] read_margin, // its margin level
	input wire logic secured // secured state
);
	// ======================================================================
	// clock and reset of every property
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	chk_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("access stalled past one cycle");
	chk_bus_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("stall without a request");
	chk_key_addr: assert property (key_rd_addr[22:8] == 15'h7FFF
		&& key_rd_addr[7:3] == 5'h00 && !key_rd_addr[0]) else $error("key address off range");
	chk_key_order: assert property ($changed(key_rd_addr) |-> key_rd_addr == 23'h7F_FF00
		|| key_rd_addr == $past(key_rd_addr) + 23'h00_0002) else $error("key fetch out of order");
	chk_status_zero: assert property (avs_read && !avs_waitrequest && avs_address == 5'h00
		|-> avs_readdata[4] == 1'b0 && avs_readdata[1:0] == 2'b00) else $error("status bit set");
	chk_secured_rise: assert property ($rose(secured) |-> $past(avs_write)
		&& $past(avs_address) == 5'h0C) else $error("security raised without a write");
	chk_margin_reset: assert property ($rose(resetn) |-> read_margin == 3'h0)
		else $error("margin not normal after reset");
	chk_margin_range: assert property (read_margin <= 3'h4)
		else $error("margin level out of range");
	chk_margin_hold: assert property ((!avs_write && $stable(read_block)) [*4]
		|=> $stable(read_margin)) else $error("margin level changed by itself");
endmodule // fkm_top_sva

bind fkm_top fkm_top_sva #(.NUM_BLOCKS(NUM_BLOCKS)) chk_u (.clk(clk), .resetn(resetn),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.special_mode_pin(special_mode_pin), .key_rd_addr(key_rd_addr),
	.key_rd_data(key_rd_data), .read_block(read_block), .read_margin(read_margin),
	.secured(secured));

// ---- test/tb_top.sv ----
/*
 * Self-checking bench for fkm_top: reset state, margins, key check and lockout.
 * Assumes the checker file is compiled with it and binds itself.
 */
`timescale 1ns/100ps

module tb_top;
	// ======================================================================
	// signals
	logic clk;
	logic resetn;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic special_mode_pin;
	logic [22:0] key_rd_addr;
	logic [15:0] key_rd_data;
	logic [6:0] read_block;
	logic [2:0] read_margin;
	logic secured;
	logic [15:0] skey [4];
	logic [15:0] cw [5];
	int fail_count;
	int checked;

	fkm_top #(.NUM_BLOCKS(2)) dut_u (.clk(clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .special_mode_pin(special_mode_pin),
		.key_rd_addr(key_rd_addr), .key_rd_data(key_rd_data), .read_block(read_block),
		.read_margin(read_margin), .secured(secured));

	// stored comparison words
	assign key_rd_data = skey[key_rd_addr[2:1]];

	// clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ======================================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (fail_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic do_reset();
		resetn <= 1'b0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
	endtask

	// one access, held until the stall is seen low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0000_0000, q);
	endtask

	// load words, launch, then only poll
	task automatic launch(input int n, input logic [2:0] idx, output logic [31:0] st);
		for (int i = 0; i < n; i++) begin
			wr(5'h04, 32'(i));
			wr(5'h08, {16'h0000, cw[i]});
		end
		wr(5'h04, {29'h0000_0000, idx});
		wr(5'h00, 32'h0000_00A0);
		st = 32'h0000_0000;
		while (st[7] !== 1'b1) rd(5'h00, st);
	endtask

	// the bench is the software and runs no code from the key block
	task automatic key_cmd(input logic [15:0] k3, input logic [2:0] idx, output logic [31:0] st);
		cw[0] = 16'h0C00;
		for (int i = 0; i < 3; i++) cw[i + 1] = skey[i];
		cw[4] = k3;
		launch(5, idx, st);
	endtask

	// block in word 0, setting in word 1
	task automatic mg_cmd(input logic [7:0] code, input logic [6:0] blk, input logic [15:0] s,
		input logic [2:0] idx, output logic [31:0] st);
		cw[0] = {code, 1'b0, blk};
		cw[1] = s;
		launch(2, idx, st);
	endtask

	// ======================================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] q;
		rd(5'h00, q);
		check(q, 32'h0000_0080);
		rd(5'h0C, q);
		check(q, 32'h0000_00FF);
		rd(5'h14, q);
		check(q, 32'h0000_0000);
		check(32'(read_margin), 32'h0000_0000);
	endtask

	// settings 0 to 5 of both margin commands in both modes, then bad block and index
	// field levels are set here only as a factory verify pass
	task automatic t_margin();
		logic [31:0] st;
		logic [2:0] lvl [2];
		logic ok;
		logic [31:0] q;
		lvl[0] = 3'h0;
		lvl[1] = 3'h0;
		for (int m = 0; m < 2; m++) begin
			special_mode_pin <= 1'(m);
			for (int c = 0; c < 2; c++) begin
				for (int s = 0; s < 6; s++) begin
					mg_cmd(8'h0D + 8'(c), 7'(s % 2), 16'(s), 3'b001, st);
					ok = (c == 0 || m == 1) && s <= (c == 1 ? 4 : 2);
					if (ok) lvl[s % 2] = 3'(s);
					check(st, ok ? 32'h0000_0080 : 32'h0000_00A0);
					for (int b = 0; b < 2; b++) begin
						read_block <= 7'(b);
						repeat (2) @(posedge clk);
						check(32'(read_margin), 32'(lvl[b]));
						wr(5'h10, 32'(b));
						rd(5'h10, q);
						check(q, {13'h0000, lvl[b], 9'h000, 7'(b)});
					end
				end
			end
		end
		mg_cmd(8'h0D, 7'h02, 16'h0001, 3'b001, st);
		check(st, 32'h0000_00A0);
		mg_cmd(8'h0E, 7'h01, 16'h0001, 3'b000, st);
		check(st, 32'h0000_00A0);
		repeat (2) @(posedge clk);
		check(32'(read_margin), 32'(lvl[1]));
	endtask

	// disabled, bad index, match, mismatch, lockout, cleared by reset
	task automatic t_key();
		logic [31:0] st;
		key_cmd(skey[3], 3'b100, st);
		check(st, 32'h0000_00A0);
		wr(5'h0C, 32'h0000_0080);
		key_cmd(skey[3], 3'b011, st);
		check(st, 32'h0000_00A0);
		key_cmd(skey[3], 3'b100, st);
		check(st, 32'h0000_0080);
		check(32'(secured), 32'h0000_0000);
		wr(5'h0C, 32'h0000_0080);
		key_cmd(skey[3] ^ 16'h0001, 3'b100, st);
		check(st, 32'h0000_00A0);
		check(32'(secured), 32'h0000_0001);
		key_cmd(skey[3], 3'b100, st);
		check(st, 32'h0000_00A0);
		do_reset();
		t_reset();
		wr(5'h0C, 32'h0000_0080);
		key_cmd(skey[3], 3'b100, st);
		check(st, 32'h0000_0080);
		check(32'(secured), 32'h0000_0000);
	endtask

	// ======================================================================
	// main sequence
	initial begin
		resetn = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		special_mode_pin = 1'b0;
		read_block = 7'h00;
		skey = '{16'h1234, 16'hA5C3, 16'h0F0F, 16'hBEEF};
		fail_count = 0;
		checked = 0;
		do_reset();
		t_reset();
		t_margin();
		t_key();
		end_sim();
	end

	// watchdog
	initial begin
		#400000;
		fail_count++;
		end_sim();
	end
endmodule // tb_top
